// ---- design/baud_timers.sv ----
// timer 1 (three running modes) and timer 2 (16-bit auto reload)
`timescale 1ns/1ps
module baud_timers
    import uart_baud_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    timer_if.tmr      tb
);
    logic [7:0]  lo_q;
    logic [7:0]  hi_q;
    logic [15:0] t2_q;

    wire logic        t1_en = tb.t1_tick & tb.t1_run;
    wire logic [16:0] sum16 = {1'b0, hi_q, lo_q} + 17'h1;
    wire logic [13:0] sum13 = {1'b0, hi_q, lo_q[4:0]} + 14'h1;
    wire logic [8:0]  sum8  = {1'b0, lo_q} + 9'h1;
    // mode 3 halts timer 1
    wire logic wrap = t1_en & ((tb.t1_mode == 2'h0) ? sum13[13] :
                               (tb.t1_mode == 2'h1) ? sum16[16] :
                               (tb.t1_mode == T1_AUTO_RELOAD) ? sum8[8] : 1'b0);
    // in auto reload the high byte is the reload value, not a count
    wire logic [7:0] lo_n = (tb.t1_mode == 2'h0) ? {lo_q[7:5], sum13[4:0]} :
                            (tb.t1_mode == 2'h1) ? sum16[7:0] :
                            (tb.t1_mode == T1_AUTO_RELOAD) ? (sum8[8] ? hi_q : sum8[7:0]) :
                            lo_q;
    wire logic [7:0] hi_n = (tb.t1_mode == 2'h0) ? sum13[12:5] :
                            (tb.t1_mode == 2'h1) ? sum16[15:8] : hi_q;
    wire logic [16:0] t2_sum = {1'b0, t2_q} + 17'h1;
    wire logic        t2_en  = tb.t2_tick & tb.t2_run;

    assign tb.t1_lo  = lo_q;
    assign tb.t1_hi  = hi_q;
    assign tb.t1_ovf = wrap;
    assign tb.t2_cnt = t2_q;
    assign tb.t2_ovf = t2_en & t2_sum[16];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            lo_q <= RST_RELOAD;
            hi_q <= RST_RELOAD;
        end else begin
            lo_q <= tb.t1_wr_lo ? tb.wdata : (t1_en ? lo_n : lo_q);
            hi_q <= tb.t1_wr_hi ? tb.wdata : (t1_en ? hi_n : hi_q);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            t2_q <= {RST_RELOAD, RST_RELOAD};
        end else if (t2_en) begin
            t2_q <= t2_sum[16] ? tb.t2_rld : t2_sum[15:0];
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_t1_reload_high: assert property (
        (wrap && tb.t1_mode == T1_AUTO_RELOAD && !tb.t1_wr_lo) |=> lo_q == $past(hi_q))
        else $error("timer 1 did not reload from its high byte");
    a_t2_reload_pair: assert property (
        tb.t2_ovf |=> t2_q == $past(tb.t2_rld))
        else $error("timer 2 did not reload from the reload pair");
endmodule

// ---- design/uart_baud_and_multiproc_filter.sv ----
// uart baud clock generation, register port and multiprocessor receive filter
//
// How it works
// - timer1 baud: 2^double osc/(32*12*(256-reload))
// - timer2 baud: osc/(32*(65536-reload))
// - timer2 reload is high*256 plus low
// - six-clock mode doubles timer-sourced baud
// - timer2 baud mode suppresses its overflow flag
// - timer1 auto reload value lives in high byte
// - either clock select enters timer2 baud mode
// - timer1 any running mode, timer or counter
// - address filter only in modes 2, 3
// - ninth bit stored in rx_ninth_bit
// - multiproc set: only ninth bit 1 interrupts
// - mode 0 ignores multiproc_enable
// - mode 1 multiproc needs valid stop bit
// - mode 2 fixed osc/64 or osc/32, doubled; the code also doubles it in six-clock mode (osc/16 with both)
// - rx and tx sources selected independently
// - load only if done clear and filter passes
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module uart_baud_and_multiproc_filter
    import uart_baud_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_t1_event,
    input  wire logic       i_t2_event,
    input  wire logic       i_rx_frame_done,
    input  wire logic [7:0] i_rx_data,
    input  wire logic       i_rx_bit9,
    output logic            o_rx_tick16,
    output logic            o_tx_bit_tick,
    output logic      [1:0] o_mode,
    output logic            o_rx_enable,
    output logic            o_tx_ninth_bit,
    output logic            o_rx_done,
    output logic            o_t1_ovf_req,
    output logic            o_t2_ovf_req
);
    function automatic logic at(input logic [3:0] a, input logic [3:0] b);
        at = (a == b);
    endfunction

    // sh selects a period of 4, 2 or 1 clocks from the free counter
    function automatic logic period_hit(input logic [1:0] c, input logic [1:0] sh);
        period_hit = (sh == 2'h0) ? (c == 2'h3) : ((sh == 2'h1) ? c[0] : 1'b1);
    endfunction

    // mode 0 shift clock, mode 2 fixed clock, else the timer source
    function automatic logic pick(input logic [1:0] m, input logic s0,
                                  input logic s2, input logic sv);
        pick = (m == MODE_0) ? s0 : ((m == MODE_2) ? s2 : sv);
    endfunction

    timer_if tb ();

    baud_timers u_timers (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .tb    (tb.tmr)
    );

    logic [7:0] serial_control_q;
    logic [7:0] serial_control_d;
    logic [7:0] rx_buf_q;
    logic       baud_double_bit_q;
    logic       six_q;
    logic [7:0] t1c_q;
    logic [7:0] t1c_d;
    logic [7:0] t2c_q;
    logic [7:0] t2c_d;
    logic [7:0] rld_lo_q;
    logic [7:0] rld_hi_q;
    logic [7:0] rdata_q;
    logic [3:0] pre_q;
    logic [1:0] fc_q;
    logic       ev1_q;
    logic       ev2_q;
    logic       t1_half_q;
    logic [3:0] txd_q;
    logic       rx_tick_q;
    logic       tx_tick_q;

    // write decode
    wire logic wr_sc  = i_wr & at(i_addr, A_SERIAL_CONTROL);
    wire logic wr_pc  = i_wr & at(i_addr, A_POWER_CONTROL);
    wire logic wr_t1c = i_wr & at(i_addr, A_TIMER1_CONTROL);
    wire logic wr_t2c = i_wr & at(i_addr, A_TIMER2_CONTROL);
    wire logic wr_rl  = i_wr & at(i_addr, A_TIMER2_RELOAD_LOW);
    wire logic wr_rh  = i_wr & at(i_addr, A_TIMER2_RELOAD_HIGH);

    // fields
    wire logic [1:0] mode = serial_control_q[SC_MODE+1:SC_MODE];
    wire logic       sm2  = serial_control_q[SC_MULTIPROC];
    wire logic       ri   = serial_control_q[SC_RX_DONE];
    wire logic rx_sel2 = t2c_q[T2_RX_CLOCK_SELECT];
    wire logic tx_sel2 = t2c_q[T2_TX_CLOCK_SELECT];
    wire logic baud2   = rx_sel2 | tx_sel2;

    // receive filter; in mode 1 the ninth input carries the stop bit
    wire logic filt_pass = (mode == MODE_0) | ~sm2 | i_rx_bit9;
    wire logic rx_accept = i_rx_frame_done & ~ri & filt_pass;
    wire logic rb8_load  = rx_accept & (mode != MODE_0);

    // a frame accepted in the clearing cycle still sets the done flag
    assign serial_control_d[7:SC_TX_NINTH] = wr_sc ? i_wdata[7:SC_TX_NINTH] : serial_control_q[7:SC_TX_NINTH];
    assign serial_control_d[SC_RX_NINTH]   = rb8_load ? i_rx_bit9 :
                                   (wr_sc ? i_wdata[SC_RX_NINTH] : serial_control_q[SC_RX_NINTH]);
    assign serial_control_d[SC_RESERVED]   = 1'b0;
    assign serial_control_d[SC_RX_DONE]    = rx_accept | (wr_sc ? i_wdata[SC_RX_DONE] : ri);

    // peripheral prescaler: osc/12, or osc/6 in six-clock mode
    wire logic [3:0] pre_last = six_q ? PRESCALE_6T : PRESCALE_12T;
    wire logic       pre_hit  = (pre_q == pre_last);

    // timer 1 counts prescaled clocks or falling edges of its event pin
    wire logic ev1_fall = ev1_q & ~i_t1_event;
    wire logic ev2_fall = ev2_q & ~i_t2_event;
    assign tb.t1_tick  = t1c_q[T1_COUNTER] ? ev1_fall : pre_hit;
    assign tb.t1_run   = t1c_q[T1_RUN];
    assign tb.t1_mode  = t1c_q[T1_MODE+1:T1_MODE];
    assign tb.t1_wr_lo = i_wr & at(i_addr, A_TIMER1_LOW);
    assign tb.t1_wr_hi = i_wr & at(i_addr, A_TIMER1_RELOAD_HIGH);
    assign tb.wdata    = i_wdata;

    // timer 2 counts osc/2, or osc in six-clock mode
    assign tb.t2_tick = t2c_q[T2_COUNTER] ? ev2_fall :
                        period_hit(fc_q, {six_q, ~six_q});
    assign tb.t2_run  = t2c_q[T2_RUN];
    assign tb.t2_rld  = {rld_hi_q, rld_lo_q};

    // oversample clocks: timer 1 halved unless baud_double_bit is set
    wire logic t1_16x = tb.t1_ovf & (baud_double_bit_q | t1_half_q);
    wire logic m2_16x = period_hit(fc_q, {baud_double_bit_q & six_q, baud_double_bit_q ^ six_q});
    wire logic rx_var = rx_sel2 ? tb.t2_ovf : t1_16x;
    wire logic tx_var = tx_sel2 ? tb.t2_ovf : t1_16x;
    wire logic rx_src = pick(mode, pre_hit, m2_16x, rx_var);
    wire logic tx_16x = pick(mode, 1'b0, m2_16x, tx_var);
    wire logic tx_src = (mode == MODE_0) ? pre_hit :
                        (tx_16x & (txd_q == TX_OVERSAMPLE_LAST));

    // overflow flags: hardware set wins over a software clear
    wire logic [7:0] t1c_w = wr_t1c ? i_wdata : t1c_q;
    wire logic [7:0] t2c_w = wr_t2c ? i_wdata : t2c_q;
    // timer 1 keeps flagging at the baud rate; software should mask it
    assign t1c_d = t1c_w | ({7'h00, tb.t1_ovf} << T1_FLAG);
    assign t2c_d = t2c_w | ({7'h00, tb.t2_ovf & ~baud2} << T2_FLAG);

    wire logic [7:0] power_control = ({7'h00, baud_double_bit_q} << PC_BAUD_DOUBLE) |
                            ({7'h00, six_q} << PC_SIX_CLOCK);

    // unmapped addresses read as zero
    wire logic [7:0] rd_mux =
        ({8{at(i_addr, A_SERIAL_CONTROL)}}     & serial_control_q)        |
        ({8{at(i_addr, A_RX_BUFFER)}}          & rx_buf_q)      |
        ({8{at(i_addr, A_POWER_CONTROL)}}      & power_control)          |
        ({8{at(i_addr, A_TIMER1_CONTROL)}}     & t1c_q)         |
        ({8{at(i_addr, A_TIMER1_LOW)}}         & tb.t1_lo)      |
        ({8{at(i_addr, A_TIMER1_RELOAD_HIGH)}} & tb.t1_hi)      |
        ({8{at(i_addr, A_TIMER2_CONTROL)}}     & t2c_q)         |
        ({8{at(i_addr, A_TIMER2_RELOAD_LOW)}}  & rld_lo_q)      |
        ({8{at(i_addr, A_TIMER2_RELOAD_HIGH)}} & rld_hi_q)      |
        ({8{at(i_addr, A_TIMER2_COUNT_LOW)}}   & tb.t2_cnt[7:0]) |
        ({8{at(i_addr, A_TIMER2_COUNT_HIGH)}}  & tb.t2_cnt[15:8]);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            serial_control_q <= RST_SERIAL_CONTROL;
        end else begin
            serial_control_q <= serial_control_d;
        end
    end

    // buffer holds while the done flag is set
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_buf_q <= RST_RELOAD;
        end else if (rx_accept) begin
            rx_buf_q <= i_rx_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            baud_double_bit_q <= RST_POWER_BIT;
            six_q  <= RST_POWER_BIT;
        end else if (wr_pc) begin
            baud_double_bit_q <= i_wdata[PC_BAUD_DOUBLE];
            six_q  <= i_wdata[PC_SIX_CLOCK];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            t1c_q <= RST_TIMER_CONTROL;
            t2c_q <= RST_TIMER_CONTROL;
        end else begin
            t1c_q <= t1c_d;
            t2c_q <= t2c_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rld_lo_q <= RST_RELOAD;
            rld_hi_q <= RST_RELOAD;
        end else begin
            rld_lo_q <= wr_rl ? i_wdata : rld_lo_q;
            rld_hi_q <= wr_rh ? i_wdata : rld_hi_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= i_rd ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pre_q <= 4'h0;
            fc_q  <= 2'h0;
        end else begin
            pre_q <= pre_hit ? 4'h0 : pre_q + 4'h1;
            fc_q  <= fc_q + 2'h1;
        end
    end

    // event samples start high, so a pin that is low as reset ends reads as a falling edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ev1_q <= 1'b1;
            ev2_q <= 1'b1;
        end else begin
            ev1_q <= i_t1_event;
            ev2_q <= i_t2_event;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            t1_half_q <= 1'b0;
            txd_q     <= 4'h0;
        end else begin
            t1_half_q <= t1_half_q ^ tb.t1_ovf;
            txd_q     <= tx_16x ? txd_q + 4'h1 : txd_q;
        end
    end

    // ticks are registered, one clock behind their source
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rx_tick_q <= 1'b0;
            tx_tick_q <= 1'b0;
        end else begin
            rx_tick_q <= rx_src;
            tx_tick_q <= tx_src;
        end
    end

    assign o_rdata        = rdata_q;
    assign o_rx_tick16    = rx_tick_q;
    assign o_tx_bit_tick  = tx_tick_q;
    assign o_mode         = mode;
    assign o_rx_enable    = serial_control_q[SC_RX_ENABLE];
    assign o_tx_ninth_bit = serial_control_q[SC_TX_NINTH];
    assign o_rx_done      = ri;
    assign o_t1_ovf_req   = t1c_q[T1_FLAG];
    assign o_t2_ovf_req   = t2c_q[T2_FLAG];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    wire logic m2_slow   = (mode == MODE_2) & ~baud_double_bit_q & ~six_q;
    wire logic hold_sc   = ~wr_sc;
    // a rate or mode write reaches the tick stream one clock late, so the
    // period check only runs over windows that no such write disturbs
    wire logic cfg_quiet = ~wr_sc & ~wr_pc;

    sequence s_gap_rest;
        !o_rx_tick16 [*2] ##1 o_rx_tick16;
    endsequence

    sequence s_frame_blocked;
        i_rx_frame_done && !ri && sm2 && !i_rx_bit9 && hold_sc;
    endsequence

    a_addr_frame_taken: assert property (
        (i_rx_frame_done && !ri && mode != MODE_0 && i_rx_bit9)
        |=> ri && rx_buf_q == $past(i_rx_data))
        else $error("address frame not taken");
    a_data_frame_drop: assert property (
        (s_frame_blocked and mode[1]) |=> !ri ##1 !ri || $past(wr_sc))
        else $error("data frame raised done with multiproc set");
    a_mode1_stop_check: assert property (
        (s_frame_blocked and mode == 2'h1) |=> !ri && $stable(rx_buf_q))
        else $error("mode 1 frame with bad stop bit taken");
    a_mode0_ignores: assert property (
        (i_rx_frame_done && !ri && mode == MODE_0 && sm2 && !i_rx_bit9) |=> ri)
        else $error("mode 0 frame filtered");
    a_full_buffer_hold: assert property (
        (i_rx_frame_done && ri) |=> $stable(rx_buf_q))
        else $error("buffer overwritten while done flag set");
    a_ninth_bit_store: assert property (
        (rx_accept && mode[1]) |=> serial_control_q[SC_RX_NINTH] == $past(i_rx_bit9))
        else $error("ninth bit not stored");
    a_t2_flag_quiet: assert property (
        (baud2 && !t2c_q[T2_FLAG] && !wr_t2c) |=> !t2c_q[T2_FLAG])
        else $error("timer 2 flag set in baud mode");
    a_mode2_fixed_rate: assert property (
        (m2_slow && o_rx_tick16 && cfg_quiet) ##1 cfg_quiet [*2]
        |-> !$past(o_rx_tick16) ##0 s_gap_rest)
        else $error("mode 2 oversample period not four clocks");
    a_t1_source_pick: assert property (
        (mode[0] && !rx_sel2 && tb.t1_ovf && baud_double_bit_q) |=> o_rx_tick16)
        else $error("receive clock not from timer 1");
    a_t2_rx_source: assert property (
        (mode[0] && rx_sel2 && tb.t2_ovf) |=> o_rx_tick16)
        else $error("receive clock not from timer 2");

    // a transmit bit spans sixteen oversample ticks of its source
    a_t2_tx_count: assert property (
        (mode[0] && tx_sel2 && tb.t2_ovf && txd_q == TX_OVERSAMPLE_LAST) |=> o_tx_bit_tick)
        else $error("transmit bit clock not every sixteenth timer 2 overflow");
    a_t1_flag_set: assert property (
        tb.t1_ovf |=> o_t1_ovf_req)
        else $error("timer 1 overflow not flagged");

    // the clear must win whenever no frame is accepted in that cycle
    a_rx_done_clear: assert property (
        (wr_sc && !i_wdata[SC_RX_DONE] && !rx_accept) |=> !ri)
        else $error("done flag survived a software clear");
endmodule

// ---- pkg/timer_if.sv ----
// carrier between the register side and the two baud timers
`timescale 1ns/1ps
interface timer_if;
    logic        t1_tick;
    logic        t1_run;
    logic [1:0]  t1_mode;
    logic        t1_wr_lo;
    logic        t1_wr_hi;
    logic [7:0]  wdata;
    logic [7:0]  t1_lo;
    logic [7:0]  t1_hi;
    logic        t1_ovf;
    logic        t2_tick;
    logic        t2_run;
    logic [15:0] t2_rld;
    logic [15:0] t2_cnt;
    logic        t2_ovf;
    modport ctl (output t1_tick, t1_run, t1_mode, t1_wr_lo, t1_wr_hi, wdata,
                 output t2_tick, t2_run, t2_rld,
                 input  t1_lo, t1_hi, t1_ovf, t2_cnt, t2_ovf);
    modport tmr (input  t1_tick, t1_run, t1_mode, t1_wr_lo, t1_wr_hi, wdata,
                 input  t2_tick, t2_run, t2_rld,
                 output t1_lo, t1_hi, t1_ovf, t2_cnt, t2_ovf);
endinterface

// ---- pkg/uart_baud_pkg.sv ----
// register map, field positions, reset values and divider counts
package uart_baud_pkg;
    localparam logic [3:0] A_SERIAL_CONTROL     = 4'h0;
    localparam logic [3:0] A_RX_BUFFER          = 4'h1;
    localparam logic [3:0] A_POWER_CONTROL      = 4'h2;
    localparam logic [3:0] A_TIMER1_CONTROL     = 4'h3;
    localparam logic [3:0] A_TIMER1_LOW         = 4'h4;
    localparam logic [3:0] A_TIMER1_RELOAD_HIGH = 4'h5;
    localparam logic [3:0] A_TIMER2_CONTROL     = 4'h6;
    localparam logic [3:0] A_TIMER2_RELOAD_LOW  = 4'h7;
    localparam logic [3:0] A_TIMER2_RELOAD_HIGH = 4'h8;
    localparam logic [3:0] A_TIMER2_COUNT_LOW   = 4'h9;
    localparam logic [3:0] A_TIMER2_COUNT_HIGH  = 4'ha;

    // serial_control
    localparam int SC_MODE      = 6;
    localparam int SC_MULTIPROC = 5;
    localparam int SC_RX_ENABLE = 4;
    localparam int SC_TX_NINTH  = 3;
    localparam int SC_RX_NINTH  = 2;
    localparam int SC_RESERVED  = 1;
    localparam int SC_RX_DONE   = 0;
    // power_control
    localparam int PC_BAUD_DOUBLE = 7;
    localparam int PC_SIX_CLOCK   = 0;
    // timer1 control
    localparam int T1_RUN     = 7;
    localparam int T1_COUNTER = 6;
    localparam int T1_FLAG    = 5;
    localparam int T1_MODE    = 0;
    // timer2_control
    localparam int T2_FLAG            = 7;
    localparam int T2_RX_CLOCK_SELECT = 5;
    localparam int T2_TX_CLOCK_SELECT = 4;
    localparam int T2_RUN             = 2;
    localparam int T2_COUNTER         = 1;

    localparam logic [7:0] RST_SERIAL_CONTROL = 8'h00;
    localparam logic [7:0] RST_TIMER_CONTROL  = 8'h00;
    localparam logic [7:0] RST_RELOAD         = 8'h00;
    localparam logic       RST_POWER_BIT      = 1'b0;

    localparam logic [1:0] MODE_0 = 2'h0;
    localparam logic [1:0] MODE_2 = 2'h2;
    localparam logic [1:0] T1_AUTO_RELOAD = 2'h2;

    // last count of the peripheral prescaler (divide by 12 or by 6)
    localparam logic [3:0] PRESCALE_12T = 4'hb;
    localparam logic [3:0] PRESCALE_6T  = 4'h5;
    // transmit bit clock is the sixteenth tick of the oversample clock
    localparam logic [3:0] TX_OVERSAMPLE_LAST = 4'hf;
endpackage

// ---- verification/tb_top.sv ----
// self-checking bench for baud generation and multiprocessor receive filter
`timescale 1ns/1ps
module tb_top
    import uart_baud_pkg::*;
;
    logic       clk;
    logic       rst;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       t1_event;
    logic       ev_run;
    logic       frame_done;
    logic [7:0] rx_data;
    logic       rx_bit9;
    logic       rx_tick16;
    logic       tx_bit_tick;
    logic       rx_done;
    logic       t2_ovf_req;
    logic       t1_ovf_req;
    logic [1:0] ser_mode;
    logic       rx_enable;
    logic       tx_ninth;
    int         miscompares;
    int         checks_done;

    uart_baud_and_multiproc_filter uart_baud_and_multiproc_filter_i (
        .i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_t1_event(t1_event), .i_t2_event(1'b1),
        .i_rx_frame_done(frame_done), .i_rx_data(rx_data), .i_rx_bit9(rx_bit9),
        .o_rx_tick16(rx_tick16), .o_tx_bit_tick(tx_bit_tick), .o_mode(ser_mode),
        .o_rx_enable(rx_enable), .o_tx_ninth_bit(tx_ninth), .o_rx_done(rx_done),
        .o_t1_ovf_req(t1_ovf_req), .o_t2_ovf_req(t2_ovf_req)
    );

    uart_node_model uart_node_model_i (
        .i_clk(clk), .o_frame_done(frame_done), .o_data(rx_data), .o_bit9(rx_bit9)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // external count pin: one falling edge every two clocks while enabled
    always @(posedge clk) begin
        if (ev_run) begin
            t1_event <= ~t1_event;
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // gap between the second and third pulse; the first may predate the setup
    // and a timer counting up from reset can take a full wrap before it settles
    task automatic gap_is(input string name, input logic use_tx, input logic [15:0] exp);
        int          n;
        int          seen;
        logic [15:0] gap;
        n = 0;
        seen = 0;
        gap = 16'h0000;
        while (seen < 3 && n < 70000) begin
            @(posedge clk);
            #1;
            n++;
            if (seen == 2) gap++;
            if ((use_tx ? tx_bit_tick : rx_tick16) === 1'b1) seen++;
        end
        if (seen < 3) begin
            miscompares++;
            print_verdict();
        end else begin
            check(name, gap, exp);
        end
    endtask

    // two counts below the wrap; the flag keeps rising, so the control is written twice to clear it
    task automatic timer1_wrap(input logic [7:0] ctl);
        logic [7:0] d;
        reg_wr(A_TIMER1_CONTROL, 8'h00);
        reg_wr(A_TIMER1_CONTROL, 8'h00);
        reg_wr(A_TIMER1_LOW, 8'hfe);
        reg_wr(A_TIMER1_RELOAD_HIGH, 8'hff);
        #1;
        check("t1_flag_clear", 16'(t1_ovf_req), 16'h0000);
        reg_wr(A_TIMER1_CONTROL, ctl);
        repeat (30) @(posedge clk);
        #1;
        check("t1_flag_set", 16'(t1_ovf_req), 16'h0001);
        reg_rd(A_TIMER1_RELOAD_HIGH, d);
        check("t1_wrap_high", 16'(d), 16'h0000);
    endtask

    task automatic reset_values();
        logic [7:0] d;
        reg_rd(A_SERIAL_CONTROL, d);
        check("serial_control", 16'(d), 16'(RST_SERIAL_CONTROL));
        reg_rd(A_TIMER2_CONTROL, d);
        check("timer2_control", 16'(d), 16'(RST_TIMER_CONTROL));
        reg_wr(A_SERIAL_CONTROL, 8'h58);
        #1;
        check("mode_out", 16'(ser_mode), 16'h0001);
        check("rx_enable", 16'(rx_enable), 16'h0001);
        check("tx_ninth", 16'(tx_ninth), 16'h0001);
        reg_wr(4'hb, 8'hff);
        reg_rd(4'hb, d);
        check("unmapped", 16'(d), 16'h0000);
    endtask

    task automatic filter_case(input logic [7:0] cfg, input logic b9, input logic exp);
        logic [7:0] d;
        reg_wr(A_SERIAL_CONTROL, cfg);
        uart_node_model_i.send(8'h5a ^ cfg, b9);
        repeat (2) @(posedge clk);
        #1;
        check("rx_done", 16'(rx_done), 16'(exp));
        if (exp) begin
            reg_rd(A_RX_BUFFER, d);
            check("rx_buffer", 16'(d), 16'(8'h5a ^ cfg));
            reg_rd(A_SERIAL_CONTROL, d);
            if (cfg[7:6] != MODE_0) check("rx_ninth", 16'(d[SC_RX_NINTH]), 16'(b9));
        end
    endtask

    task automatic filter_modes();
        filter_case(8'hb0, 1'b0, 1'b0);
        filter_case(8'hb0, 1'b1, 1'b1);
        filter_case(8'hf0, 1'b0, 1'b0);
        filter_case(8'hf0, 1'b1, 1'b1);
        filter_case(8'h30, 1'b0, 1'b1);
        filter_case(8'h70, 1'b0, 1'b0);
        filter_case(8'h70, 1'b1, 1'b1);
        filter_case(8'h90, 1'b0, 1'b1);
    endtask

    task automatic addressed_block();
        logic [7:0] d;
        reg_wr(A_SERIAL_CONTROL, 8'hb0);
        uart_node_model_i.send(8'h21, 1'b1);
        reg_rd(A_RX_BUFFER, d);
        check("address", 16'(d), 16'h0021);
        reg_wr(A_SERIAL_CONTROL, 8'h90);
        uart_node_model_i.send(8'h3c, 1'b0);
        uart_node_model_i.send(8'hc3, 1'b0);
        reg_rd(A_RX_BUFFER, d);
        check("held_byte", 16'(d), 16'h003c);
        reg_wr(A_SERIAL_CONTROL, 8'hb0);
        uart_node_model_i.send(8'h77, 1'b0);
        repeat (2) @(posedge clk);
        #1;
        check("block_end", 16'(rx_done), 16'h0000);
    endtask

    task automatic mode2_rate();
        reg_wr(A_SERIAL_CONTROL, 8'h80);
        reg_wr(A_POWER_CONTROL, 8'h00);
        gap_is("mode2_12t", 1'b0, 16'h0004);
        reg_wr(A_POWER_CONTROL, 8'h80);
        gap_is("mode2_double", 1'b0, 16'h0002);
        reg_wr(A_POWER_CONTROL, 8'h01);
        gap_is("mode2_6t", 1'b0, 16'h0002);
    endtask

    task automatic timer1_rate();
        reg_wr(A_SERIAL_CONTROL, 8'hc0);
        reg_wr(A_POWER_CONTROL, 8'h00);
        reg_wr(A_TIMER1_RELOAD_HIGH, 8'hfe);
        reg_wr(A_TIMER1_CONTROL, 8'h82);
        gap_is("t1_12t", 1'b0, 16'h0030);
        reg_wr(A_TIMER1_RELOAD_HIGH, 8'hfd);
        gap_is("t1_reload", 1'b0, 16'h0048);
        reg_wr(A_POWER_CONTROL, 8'h80);
        gap_is("t1_double", 1'b0, 16'h0024);
        reg_wr(A_POWER_CONTROL, 8'h01);
        gap_is("t1_6t", 1'b0, 16'h0024);
        reg_wr(A_POWER_CONTROL, 8'h00);
        ev_run <= 1'b1;
        reg_wr(A_TIMER1_CONTROL, 8'hc2);
        gap_is("t1_events", 1'b0, 16'h000c);
        ev_run <= 1'b0;
        timer1_wrap(8'h80);
        timer1_wrap(8'h81);
        reg_wr(A_TIMER1_RELOAD_HIGH, 8'hfd);
        reg_wr(A_TIMER1_CONTROL, 8'h82);
    endtask

    // six-clock first so the wrap up from a zero count stays short
    task automatic timer2_rate();
        reg_wr(A_POWER_CONTROL, 8'h01);
        reg_wr(A_TIMER2_RELOAD_LOW, 8'hfc);
        reg_wr(A_TIMER2_RELOAD_HIGH, 8'hff);
        reg_wr(A_TIMER2_CONTROL, 8'h34);
        gap_is("t2_6t", 1'b0, 16'h0004);
        reg_wr(A_POWER_CONTROL, 8'h00);
        gap_is("t2_rx", 1'b0, 16'h0008);
        gap_is("t2_tx", 1'b1, 16'h0080);
        check("t2_flag", 16'(t2_ovf_req), 16'h0000);
        reg_wr(A_TIMER2_CONTROL, 8'h14);
        gap_is("t1_rx_t2_tx", 1'b0, 16'h0048);
        gap_is("t2_tx_only", 1'b1, 16'h0080);
        reg_wr(A_TIMER2_CONTROL, 8'h24);
        gap_is("t2_rx_only", 1'b0, 16'h0008);
    endtask

    initial begin
        rst = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        t1_event = 1'b1;
        ev_run = 1'b0;
        miscompares = 0;
        checks_done = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        reset_values();
        filter_modes();
        addressed_block();
        mode2_rate();
        timer1_rate();
        timer2_rate();
        print_verdict();
    end
endmodule

// ---- verification/uart_node_model.sv ----
// far-side serial node handing completed receive frames to the block
`timescale 1ns/1ps
module uart_node_model (
    input  wire logic       i_clk,
    output logic            o_frame_done,
    output logic      [7:0] o_data,
    output logic            o_bit9
);
    initial begin
        o_frame_done = 1'b0;
        o_data       = 8'h00;
        o_bit9       = 1'b0;
    end

    // data is valid only beside the pulse; afterwards the lines carry junk
    task automatic send(input logic [7:0] d, input logic b9);
        @(posedge i_clk);
        o_frame_done <= 1'b1;
        o_data       <= d;
        o_bit9       <= b9;
        @(posedge i_clk);
        o_frame_done <= 1'b0;
        o_data       <= ~d;
        o_bit9       <= ~b9;
    endtask
endmodule
